//--- acs_consts.svh
/*
  Timing counts, step counts and code values for the checkout sequencer.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_CLK_PERIOD_NS 10
`define ACS_SELF_STEPS 18
`define ACS_FAULT_STEPS 21
`define ACS_IDX_W 8
`define ACS_CMD_W 16
`define ACS_CHAR_W 8
`define ACS_LIM_W 16
`define ACS_CAL_STEPS 2
`define ACS_TIMER_W 32
`define ACS_PULSE_NS 2000
`define ACS_PULSE_CYC ((`ACS_PULSE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_FLOW_SELF 2'h0
`define ACS_FLOW_SUB 2'h1
`define ACS_FLOW_FAULT 2'h2
`define ACS_SRC_TAPE 2'h0
`define ACS_SRC_MANUAL 2'h1
`define ACS_SRC_SYSTEM 2'h2
`define ACS_TAG_TEST 4'h1
`define ACS_TAG_LIMIT_LO 4'h2
`define ACS_TAG_LIMIT_HI 4'h3
`define ACS_TAG_CMD_CHAR 4'h4
`define ACS_TAG_CTRL 4'h5
`define ACS_TAG_END 4'h6
`define ACS_TAG_RESET 4'h7
`define ACS_TAG_BURST_END 4'h8

`endif

//--- acs_pkg.sv
/*
  Types for the checkout sequencer.
  Assumes acs_consts.svh is available.
*/
package acs_pkg;
  typedef enum logic [11:0] {
    ACS_IDLE = 12'h001,
    ACS_CAL = 12'h002,
    ACS_RESET = 12'h004,
    ACS_POWER = 12'h008,
    ACS_PREP = 12'h010,
    ACS_LOAD = 12'h020,
    ACS_SEND = 12'h040,
    ACS_FETCH = 12'h080,
    ACS_GATE = 12'h100,
    ACS_JUDGE = 12'h200,
    ACS_HALT = 12'h400,
    ACS_DONE = 12'h800
  } acs_state_t;
endpackage

//--- acs_sequencer.sv
/*
  Automatic checkout sequencer: runs self-check, subsystem and fault
  isolation flows from a tape program and drives the unit under test.
  Assumes tape words arrive synchronously with a valid strobe; pin-level
  start, resp_in and telemetry are asynchronous and synchronised here; shape_ok_in goes to the window unsynchronised.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_sequencer (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [1:0] flow_in,
  input wire logic [1:0] src_in,
  input wire logic [1:0] corner_in,
  input wire logic tape_valid_in,
  input wire logic [3:0] tape_tag_in,
  input wire logic [`ACS_CMD_W-1:0] tape_data_in,
  input wire logic [`ACS_CMD_W-1:0] manual_word_in,
  input wire logic manual_send_in,
  input wire logic [`ACS_CMD_W-1:0] system_word_in,
  input wire logic cal_ok_in,
  input wire logic cyclic_ok_in,
  input wire logic resp_in,
  input wire logic shape_ok_in,
  input wire logic supply_ok_in,
  input wire logic telem_ok_in,
  input wire logic speedup_in,
  output logic tape_ready_out,
  output logic [`ACS_IDX_W-1:0] index_out,
  output logic fail_out,
  output logic complete_out,
  output logic busy_out,
  output logic uut_power_out,
  output logic loopback_out,
  output logic [1:0] corner_out,
  output logic [`ACS_CMD_W-1:0] ctrl_out,
  output logic regs_reset_out,
  output logic elapsed_run_out,
  output logic timer_reset_out,
  output logic alert_out,
  output logic sync_out,
  output logic cmd_valid_out,
  output logic [`ACS_CMD_W-1:0] cmd_word_out
);
  // Asynchronous pins: three stages, change taken when 2nd and 3rd agree
  localparam int NS = 7;
  logic [NS-1:0] s1_q, s2_q, s3_q, clean_q, clean_d;
  logic [NS-1:0] raw;
  assign raw = {start_in, cal_ok_in, cyclic_ok_in, resp_in,
                supply_ok_in, telem_ok_in, speedup_in};

  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < NS; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else if (ce_in) begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  logic start_s, cal_s, cyc_s, resp_s, sup_s, tel_s, spd_s;
  assign {start_s, cal_s, cyc_s, resp_s, sup_s, tel_s, spd_s} = clean_q;

  // Main sequencer state
  acs_pkg::acs_state_t st_q, st_d;
  logic [1:0] flow_q, flow_d;
  logic [1:0] src_q, src_d;
  logic start_prev_q, start_prev_d;
  logic [`ACS_IDX_W-1:0] idx_q, idx_d;
  logic [`ACS_LIM_W-1:0] lo_q, lo_d, hi_q, hi_d;
  logic [`ACS_CMD_W-1:0] ctrl_q, ctrl_d;
  logic [`ACS_CMD_W-1:0] word_q, word_d;
  logic half_q, half_d;
  logic [`ACS_CMD_W-1:0] burst_q [0:15];
  logic [3:0] wr_q, wr_d, rd_q, rd_d;
  logic burst_we;
  logic [`ACS_CMD_W-1:0] burst_wd;
  logic [11:0] pcnt_q, pcnt_d;
  logic fail_q, fail_d, comp_q, comp_d;
  logic pwr_q, pwr_d, loop_q, loop_d, rreg_q, rreg_d;
  logic etc_q, etc_d, trst_q, trst_d, alert_q, alert_d, sync_q, sync_d;
  logic cv_q, cv_d;
  logic [`ACS_CMD_W-1:0] cw_q, cw_d;
  logic arm_q, arm_d;
  logic tr_q, tr_d;
  logic busy_q, busy_d;
  logic win_done, win_pass;
  logic [`ACS_IDX_W-1:0] last_idx;
  logic start_edge, take;
  logic [`ACS_CMD_W-1:0] src_word;

  assign start_edge = start_s && !start_prev_q;
  assign take = tape_valid_in && tr_q;
  assign last_idx = (flow_q == `ACS_FLOW_SELF) ?
                    `ACS_IDX_W'(`ACS_SELF_STEPS) :
                    `ACS_IDX_W'(`ACS_FAULT_STEPS);
  assign src_word = (src_q == `ACS_SRC_SYSTEM) ? system_word_in :
                    tape_data_in;

  acs_window u_win (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .arm_in(arm_q),
    .lo_in(lo_q),
    .hi_in(hi_q),
    .resp_in(resp_s),
    .shape_ok_in(shape_ok_in),
    .done_out(win_done),
    .pass_out(win_pass)
  );

  always_comb begin
    st_d = st_q;
    flow_d = flow_q;
    src_d = src_q;
    start_prev_d = start_s;
    idx_d = idx_q;
    lo_d = lo_q;
    hi_d = hi_q;
    ctrl_d = ctrl_q;
    word_d = word_q;
    half_d = half_q;
    wr_d = wr_q;
    rd_d = rd_q;
    burst_we = 1'b0;
    burst_wd = word_q;
    pcnt_d = pcnt_q;
    fail_d = fail_q;
    comp_d = comp_q;
    pwr_d = pwr_q;
    loop_d = loop_q;
    rreg_d = 1'b0;
    etc_d = etc_q;
    trst_d = 1'b0;
    alert_d = 1'b0;
    sync_d = sync_q;
    cv_d = 1'b0;
    cw_d = cw_q;
    arm_d = 1'b0;
    tr_d = 1'b0;
    // Manual switch bank word, only while in ACS_IDLE (not in ACS_HALT or ACS_DONE)
    if (manual_send_in && st_q == acs_pkg::ACS_IDLE) begin
      cv_d = 1'b1;
      cw_d = manual_word_in;
    end
    case (st_q)
      acs_pkg::ACS_IDLE: begin
        if (start_edge) begin
          flow_d = flow_in;
          src_d = src_in;
          idx_d = '0;
          fail_d = 1'b0;
          comp_d = 1'b0;
          if (flow_in == `ACS_FLOW_SELF) begin
            rreg_d = 1'b1;
            loop_d = 1'b1;
            st_d = acs_pkg::ACS_CAL;
          end else begin
            st_d = acs_pkg::ACS_RESET;
          end
        end
      end
      acs_pkg::ACS_CAL: begin
        // Supplies then oscillator, before any check relies on them
        if (cal_s) begin
          idx_d = idx_q + 1'b1;
          if (idx_q == `ACS_IDX_W'(`ACS_CAL_STEPS - 1)) begin
            idx_d = '0;
            st_d = acs_pkg::ACS_FETCH;
          end
        end
      end
      acs_pkg::ACS_RESET: begin
        rreg_d = 1'b1;
        st_d = acs_pkg::ACS_POWER;
      end
      acs_pkg::ACS_POWER: begin
        pwr_d = 1'b1;
        if (flow_q == `ACS_FLOW_FAULT) begin
          st_d = acs_pkg::ACS_FETCH;
        end else if (cyc_s && sup_s) begin
          etc_d = 1'b1;
          trst_d = 1'b1;
          st_d = acs_pkg::ACS_PREP;
        end
      end
      acs_pkg::ACS_PREP: begin
        if (spd_s) begin
          st_d = acs_pkg::ACS_LOAD;
          wr_d = '0;
          half_d = 1'b0;
        end
      end
      acs_pkg::ACS_LOAD: begin
        tr_d = 1'b1;
        if (take && tape_tag_in == `ACS_TAG_CMD_CHAR) begin
          // Two characters form one command word
          word_d = {word_q[`ACS_CHAR_W-1:0],
                    src_word[`ACS_CHAR_W-1:0]};
          half_d = !half_q;
          if (half_q) begin
            burst_we = 1'b1;
            burst_wd = {word_q[`ACS_CHAR_W-1:0],
                        src_word[`ACS_CHAR_W-1:0]};
            wr_d = wr_q + 1'b1;
          end
        end else if (take && tape_tag_in == `ACS_TAG_BURST_END) begin
          alert_d = 1'b1;
          rd_d = '0;
          pcnt_d = '0;
          tr_d = 1'b0;
          st_d = acs_pkg::ACS_SEND;
        end
      end
      acs_pkg::ACS_SEND: begin
        sync_d = 1'b1;
        pcnt_d = pcnt_q + 1'b1;
        if (pcnt_q == 12'(`ACS_PULSE_CYC - 1)) begin
          pcnt_d = '0;
          if (rd_q == wr_q) begin
            st_d = acs_pkg::ACS_FETCH;
          end else begin
            cv_d = 1'b1;
            cw_d = burst_q[rd_q];
            rd_d = rd_q + 1'b1;
          end
        end
      end
      acs_pkg::ACS_FETCH: begin
        tr_d = 1'b1;
        if (flow_q == `ACS_FLOW_SUB && !tel_s) begin
          fail_d = 1'b1;
          st_d = acs_pkg::ACS_HALT;
          tr_d = 1'b0;
        end else if (take) begin
          case (tape_tag_in)
            `ACS_TAG_TEST: idx_d = src_word[`ACS_IDX_W-1:0];
            `ACS_TAG_CTRL: ctrl_d = src_word;
            `ACS_TAG_LIMIT_LO: lo_d = src_word;
            `ACS_TAG_LIMIT_HI: hi_d = src_word;
            `ACS_TAG_RESET: rreg_d = 1'b1;
            `ACS_TAG_END: begin
              arm_d = 1'b1;
              tr_d = 1'b0;
              st_d = acs_pkg::ACS_GATE;
            end
            default: idx_d = idx_q;
          endcase
        end
      end
      acs_pkg::ACS_GATE: begin
        if (win_done) begin
          st_d = acs_pkg::ACS_JUDGE;
        end
      end
      acs_pkg::ACS_JUDGE: begin
        if (!win_pass || !sup_s) begin
          fail_d = 1'b1;
          st_d = acs_pkg::ACS_HALT;
        end else if (flow_q != `ACS_FLOW_SUB && idx_q >= last_idx) begin
          comp_d = 1'b1;
          st_d = acs_pkg::ACS_DONE;
        end else if (flow_q == `ACS_FLOW_SUB && ctrl_q[0]) begin
          comp_d = 1'b1;
          st_d = acs_pkg::ACS_DONE;
        end else begin
          st_d = acs_pkg::ACS_FETCH;
        end
      end
      acs_pkg::ACS_HALT: begin
        // Index stays frozen on the failed test
        pwr_d = 1'b0;
        sync_d = 1'b0;
        etc_d = 1'b0;
        loop_d = 1'b0;
        if (start_edge) begin
          st_d = acs_pkg::ACS_IDLE;
        end
      end
      acs_pkg::ACS_DONE: begin
        pwr_d = 1'b0;
        sync_d = 1'b0;
        etc_d = 1'b0;
        loop_d = 1'b0;
        if (start_edge) begin
          st_d = acs_pkg::ACS_IDLE;
        end
      end
      default: st_d = acs_pkg::ACS_IDLE;
    endcase
    busy_d = (st_d != acs_pkg::ACS_IDLE) &&
             (st_d != acs_pkg::ACS_HALT) &&
             (st_d != acs_pkg::ACS_DONE);
  end

  always_ff @(posedge clk_sys_in) begin
    if (ce_in && burst_we) begin
      burst_q[wr_q] <= burst_wd;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= acs_pkg::ACS_IDLE;
      flow_q <= 2'h0;
      src_q <= 2'h0;
      start_prev_q <= 1'b0;
      idx_q <= '0;
      lo_q <= '0;
      hi_q <= '0;
      ctrl_q <= '0;
      word_q <= '0;
      half_q <= 1'b0;
      wr_q <= '0;
      rd_q <= '0;
      pcnt_q <= '0;
      fail_q <= 1'b0;
      comp_q <= 1'b0;
      pwr_q <= 1'b0;
      loop_q <= 1'b0;
      rreg_q <= 1'b0;
      etc_q <= 1'b0;
      trst_q <= 1'b0;
      alert_q <= 1'b0;
      sync_q <= 1'b0;
      cv_q <= 1'b0;
      cw_q <= '0;
      arm_q <= 1'b0;
      tr_q <= 1'b0;
      busy_q <= 1'b0;
      corner_out <= 2'h0;
    end else if (ce_in) begin
      st_q <= st_d;
      flow_q <= flow_d;
      src_q <= src_d;
      start_prev_q <= start_prev_d;
      idx_q <= idx_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      ctrl_q <= ctrl_d;
      word_q <= word_d;
      half_q <= half_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      pcnt_q <= pcnt_d;
      fail_q <= fail_d;
      comp_q <= comp_d;
      pwr_q <= pwr_d;
      loop_q <= loop_d;
      rreg_q <= rreg_d;
      etc_q <= etc_d;
      trst_q <= trst_d;
      alert_q <= alert_d;
      sync_q <= sync_d;
      cv_q <= cv_d;
      cw_q <= cw_d;
      arm_q <= arm_d;
      tr_q <= tr_d;
      busy_q <= busy_d;
      corner_out <= corner_in;
    end
  end

  assign tape_ready_out = tr_q;
  assign index_out = idx_q;
  assign fail_out = fail_q;
  assign complete_out = comp_q;
  assign busy_out = busy_q;
  assign uut_power_out = pwr_q;
  assign loopback_out = loop_q;
  assign ctrl_out = ctrl_q;
  assign regs_reset_out = rreg_q;
  assign elapsed_run_out = etc_q;
  assign timer_reset_out = trst_q;
  assign alert_out = alert_q;
  assign sync_out = sync_q;
  assign cmd_valid_out = cv_q;
  assign cmd_word_out = cw_q;
endmodule

//--- acs_sequencer_monitor.sv
/*
  Port checker for the checkout sequencer, bound into acs_sequencer.
  Assumes one clock domain and the sequencer's hand-over timing.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_seq_monitor (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic tape_ready_out,
  input wire logic [`ACS_IDX_W-1:0] index_out,
  input wire logic fail_out,
  input wire logic complete_out,
  input wire logic busy_out,
  input wire logic uut_power_out,
  input wire logic regs_reset_out,
  input wire logic alert_out,
  input wire logic sync_out,
  input wire logic cmd_valid_out
);
  logic seen_alert_q;
  logic seen_alert_d;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  // Alert seen during this run
  always_comb begin
    seen_alert_d = busy_out ? (seen_alert_q | alert_out) : 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_alert_q <= 1'b0;
    end else begin
      seen_alert_q <= seen_alert_d;
    end
  end

  flags_apart_a: assert property (!(fail_out && complete_out))
    else $error("fail and complete both high");
  fail_hold_a: assert property ((fail_out && !start_in)[*8] |=> fail_out)
    else $error("fail dropped without start");
  index_hold_a: assert property (
    (fail_out && !start_in)[*8] |=> $stable(index_out))
    else $error("index moved at halt");
  halt_no_tape_a: assert property (fail_out |-> !tape_ready_out)
    else $error("tape taken after failure");
  idle_quiet_a: assert property (
    !busy_out |-> !tape_ready_out && !alert_out)
    else $error("activity while idle");
  cmd_spacing_a: assert property (
    cmd_valid_out |=> (!cmd_valid_out)[*8])
    else $error("command words too close");
  alert_first_a: assert property (
    cmd_valid_out && sync_out |-> seen_alert_q)
    else $error("command before alert");
  alert_pulse_a: assert property (alert_out |=> !alert_out)
    else $error("alert longer than one cycle");
  reset_pulse_a: assert property (regs_reset_out |=> !regs_reset_out)
    else $error("register reset longer than one cycle");
  power_off_a: assert property (
    complete_out |-> ##[0:4] (!uut_power_out && !sync_out))
    else $error("unit left powered after completion");

  cover property (complete_out);
  cover property (fail_out);
  cover property (cmd_valid_out && sync_out);
endmodule

bind acs_sequencer acs_seq_monitor i_acs_seq_monitor (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .start_in(start_in),
  .tape_ready_out(tape_ready_out), .index_out(index_out),
  .fail_out(fail_out), .complete_out(complete_out), .busy_out(busy_out),
  .uut_power_out(uut_power_out), .regs_reset_out(regs_reset_out),
  .alert_out(alert_out), .sync_out(sync_out),
  .cmd_valid_out(cmd_valid_out)
);

//--- acs_uut_model.sv
/*
  Behavioural unit under test: status lines, speed-up and responses.
  Assumes the trigger is a one-cycle pulse from the bench.
*/
`timescale 1ns/1ps

module acs_uut_model (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic uut_power_in,
  input wire logic loopback_in,
  input wire logic timer_reset_in,
  input wire logic trig_in,
  input wire logic [15:0] delay_in,
  output logic cyclic_ok_out,
  output logic supply_ok_out,
  output logic telem_ok_out,
  output logic speedup_out,
  output logic resp_out
);
  int spd_cnt;
  int resp_cnt;

  // Status only while powered or looped back
  assign cyclic_ok_out = uut_power_in | loopback_in;
  assign supply_ok_out = uut_power_in | loopback_in;
  assign telem_ok_out = uut_power_in | loopback_in;

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      spd_cnt = 0;
      resp_cnt = 0;
      speedup_out <= 1'b0;
      resp_out <= 1'b0;
    end else begin
      if (timer_reset_in) spd_cnt = 10;
      else if (spd_cnt > 0) spd_cnt--;
      speedup_out <= (spd_cnt > 0 && spd_cnt < 5);
      if (trig_in) resp_cnt = delay_in + 4;
      else if (resp_cnt > 0) resp_cnt--;
      resp_out <= (resp_cnt > 0 && resp_cnt <= 4);
    end
  end
endmodule

//--- acs_window.sv
/*
  Response window checker: counts cycles from arm and judges a response.
  Assumes arm is a one-cycle pulse and response inputs are synchronous.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_window (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic arm_in,
  input wire logic [`ACS_LIM_W-1:0] lo_in,
  input wire logic [`ACS_LIM_W-1:0] hi_in,
  input wire logic resp_in,
  input wire logic shape_ok_in,
  output logic done_out,
  output logic pass_out
);
  logic [`ACS_LIM_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic done_q, done_d;
  logic pass_q, pass_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    pass_d = pass_q;
    if (arm_in) begin
      cnt_d = '0;
      run_d = 1'b1;
    end else if (run_q) begin
      cnt_d = cnt_q + 1'b1;
      // Accept only inside the gate and with valid shape
      if (resp_in) begin
        run_d = 1'b0;
        done_d = 1'b1;
        pass_d = (cnt_q >= lo_in) && (cnt_q <= hi_in) && shape_ok_in;
      end else if (cnt_q >= hi_in) begin
        run_d = 1'b0;
        done_d = 1'b1;
        pass_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
    end else if (ce_in) begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
      pass_q <= pass_d;
    end
  end

  assign done_out = done_q;
  assign pass_out = pass_q;
endmodule

//--- automatic_checkout_sequencer_tb.sv
/*
  Self-checking bench for the checkout sequencer and a unit model.
  Assumes tape words and switches are driven on the falling edge.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

`define ACS_CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end

module automatic_checkout_sequencer_tb;
  logic clk_sys_in, rstn_in, start_in, tape_valid_in, manual_send_in;
  logic cal_ok_in, shape_ok_in, trig, use_sys, saw_loop, ce, saw_run;
  logic cyc_ok, sup_ok, tel_ok, spd, resp;
  logic [1:0] flow_in, src_in, corner_in, corner_out;
  logic [3:0] tape_tag_in;
  logic [15:0] tape_data_in, manual_word_in, system_word_in, dly;
  logic [15:0] ctrl_out, cmd_word_out;
  logic [7:0] index_out;
  logic tape_ready_out, fail_out, complete_out, busy_out, uut_power_out;
  logic loopback_out, regs_reset_out, elapsed_run_out, timer_reset_out;
  logic alert_out, sync_out, cmd_valid_out;
  logic [15:0] cmdq[$];
  int err_total, n_compared, n_alert, n_rst, n_trst;

  acs_sequencer i_acs_sequencer (.clk_sys_in, .rstn_in, .ce_in(ce),
    .start_in, .flow_in, .src_in, .corner_in, .tape_valid_in, .tape_tag_in,
    .tape_data_in, .manual_word_in, .manual_send_in, .system_word_in,
    .cal_ok_in, .cyclic_ok_in(cyc_ok), .resp_in(resp), .shape_ok_in,
    .supply_ok_in(sup_ok), .telem_ok_in(tel_ok), .speedup_in(spd),
    .tape_ready_out, .index_out, .fail_out, .complete_out, .busy_out,
    .uut_power_out, .loopback_out, .corner_out, .ctrl_out, .regs_reset_out,
    .elapsed_run_out, .timer_reset_out, .alert_out, .sync_out,
    .cmd_valid_out, .cmd_word_out);

  acs_uut_model i_acs_uut_model (.clk_sys_in, .rstn_in,
    .uut_power_in(uut_power_out), .loopback_in(loopback_out),
    .timer_reset_in(timer_reset_out), .trig_in(trig), .delay_in(dly),
    .cyclic_ok_out(cyc_ok), .supply_ok_out(sup_ok), .telem_ok_out(tel_ok),
    .speedup_out(spd), .resp_out(resp));

  initial begin
    clk_sys_in = 0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    if (cmd_valid_out === 1'b1) cmdq.push_back(cmd_word_out);
    if (alert_out === 1'b1) n_alert++;
    if (regs_reset_out === 1'b1) n_rst++;
    if (timer_reset_out === 1'b1) n_trst++;
    if (loopback_out === 1'b1) saw_loop = 1;
    if (elapsed_run_out === 1'b1 && sync_out === 1'b1) saw_run = 1;
  end

  task wrap_up;
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task press;
    start_in = 1;
    repeat (6) @(negedge clk_sys_in);
    start_in = 0;
    repeat (6) @(negedge clk_sys_in);
  endtask

  task begin_flow(input logic [1:0] f, input logic [1:0] s);
    if (fail_out === 1'b1 || complete_out === 1'b1) press();
    flow_in = f;
    src_in = s;
    use_sys = (s == `ACS_SRC_SYSTEM);
    press();
  endtask

  task put(input logic [3:0] t, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    tape_tag_in = t;
    tape_data_in = use_sys ? ~d : d;
    system_word_in = d;
    tape_valid_in = 1;
    while (tape_ready_out !== 1'b1 && n < 4000) begin
      n++;
      @(negedge clk_sys_in);
    end
    if (n >= 4000) `ACS_CHK("tape_taken", 1'b1, 1'b0)
    @(negedge clk_sys_in);
    tape_valid_in = 0;
    tape_data_in = ~d;
  endtask

  task one(input logic [15:0] idx, lo, hi, ctrl, input logic [15:0] d);
    put(`ACS_TAG_TEST, idx);
    put(`ACS_TAG_CTRL, ctrl);
    put(`ACS_TAG_LIMIT_LO, lo);
    put(`ACS_TAG_LIMIT_HI, hi);
    put(`ACS_TAG_END, 16'h0000);
    dly = d;
    trig = 1;
    @(negedge clk_sys_in);
    trig = 0;
  endtask

  task settle(input int n);
    int k;
    k = 0;
    while (fail_out !== 1'b1 && complete_out !== 1'b1 && k < n) begin
      k++;
      @(negedge clk_sys_in);
    end
  endtask

  task sc_manual;
    corner_in = 2'h2;
    manual_word_in = 16'h5a3c;
    ce = 0;
    manual_send_in = 1;
    @(negedge clk_sys_in);
    `ACS_CHK("frozen_send", 1'b0, cmd_valid_out);
    `ACS_CHK("frozen_corner", 2'h0, corner_out);
    ce = 1;
    @(negedge clk_sys_in);
    manual_send_in = 0;
    repeat (20) @(negedge clk_sys_in);
    `ACS_CHK("manual_count", 1, cmdq.size());
    `ACS_CHK("manual_word", 16'h5a3c, cmdq[0]);
    `ACS_CHK("corner", 2'h2, corner_out);
  endtask

  task sc_self_pass;
    cal_ok_in = 0;
    saw_loop = 0;
    begin_flow(`ACS_FLOW_SELF, `ACS_SRC_TAPE);
    repeat (30) @(negedge clk_sys_in);
    `ACS_CHK("ready_before_cal", 1'b0, tape_ready_out);
    cal_ok_in = 1;
    for (int i = 1; i <= `ACS_SELF_STEPS; i++)
      one(i[15:0], 16'h0001, 16'h00c8, 16'h0000, 16'h0014);
    settle(500);
    `ACS_CHK("self_complete", 1'b1, complete_out);
    `ACS_CHK("self_fail", 1'b0, fail_out);
    `ACS_CHK("self_index", 8'h12, index_out);
    `ACS_CHK("loopback", 1'b1, saw_loop);
  endtask

  task sc_self_fail;
    begin_flow(`ACS_FLOW_SELF, `ACS_SRC_TAPE);
    for (int i = 1; i <= 4; i++)
      one(i[15:0], 16'h0001, 16'h00c8, 16'h0000, 16'h0014);
    repeat (60) @(negedge clk_sys_in);
    shape_ok_in = 0;
    one(16'h0005, 16'h0001, 16'h00c8, 16'h0000, 16'h0014);
    settle(500);
    repeat (50) @(negedge clk_sys_in);
    shape_ok_in = 1;
    `ACS_CHK("shape_fail", 1'b1, fail_out);
    `ACS_CHK("shape_index", 8'h05, index_out);
    `ACS_CHK("shape_complete", 1'b0, complete_out);
    `ACS_CHK("halt_ready", 1'b0, tape_ready_out);
  endtask

  task sc_fault_sys;
    begin_flow(`ACS_FLOW_FAULT, `ACS_SRC_SYSTEM);
    one(16'h0001, 16'h0001, 16'h00c8, 16'h0000, 16'h0014);
    one(16'h0002, 16'h0001, 16'h00c8, 16'h0000, 16'h0014);
    one(16'h0003, 16'h0028, 16'h00c8, 16'h0000, 16'h0002);
    settle(500);
    `ACS_CHK("early_fail", 1'b1, fail_out);
    `ACS_CHK("early_index", 8'h03, index_out);
    use_sys = 0;
  endtask

  task sc_sub;
    cmdq.delete();
    n_alert = 0;
    n_rst = 0;
    n_trst = 0;
    saw_run = 0;
    begin_flow(`ACS_FLOW_SUB, `ACS_SRC_TAPE);
    put(`ACS_TAG_CMD_CHAR, 16'h0012);
    put(`ACS_TAG_CMD_CHAR, 16'h0034);
    put(`ACS_TAG_CMD_CHAR, 16'h00ab);
    put(`ACS_TAG_CMD_CHAR, 16'h00cd);
    put(`ACS_TAG_CMD_CHAR, 16'h00ef);
    put(`ACS_TAG_BURST_END, 16'h0000);
    one(16'h0001, 16'h0001, 16'h00c8, 16'h0001, 16'h0014);
    settle(1500);
    repeat (6) @(negedge clk_sys_in);
    `ACS_CHK("sub_complete", 1'b1, complete_out);
    `ACS_CHK("sub_power", 1'b0, uut_power_out);
    `ACS_CHK("sub_words", 2, cmdq.size());
    `ACS_CHK("sub_word0", 16'h1234, cmdq[0]);
    `ACS_CHK("sub_word1", 16'habcd, cmdq[1]);
    `ACS_CHK("sub_alerts", 1, n_alert);
    `ACS_CHK("sub_reg_reset", 1'b1, n_rst > 0);
    `ACS_CHK("sub_timer_reset", 1'b1, n_trst > 0);
    `ACS_CHK("sub_run_sync", 1'b1, saw_run);
    `ACS_CHK("sub_ctrl", 16'h0001, ctrl_out);
    `ACS_CHK("sub_busy", 1'b0, busy_out);
    `ACS_CHK("sub_elapsed", 1'b0, elapsed_run_out);
    `ACS_CHK("sub_sync_off", 1'b0, sync_out);
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    {rstn_in, start_in, tape_valid_in, manual_send_in, trig, use_sys} = '0;
    {ce, cal_ok_in, shape_ok_in, saw_loop, saw_run} = 5'h1c;
    {flow_in, src_in, corner_in, tape_tag_in} = '0;
    {tape_data_in, manual_word_in, system_word_in, dly} = '0;
    repeat (8) @(negedge clk_sys_in);
    rstn_in = 1;
    repeat (4) @(negedge clk_sys_in);
    sc_manual();
    sc_self_pass();
    sc_self_fail();
    sc_fault_sys();
    sc_sub();
    wrap_up();
  end
endmodule
